// file: rtl/ebi_top.v
// External bus interface controller
// What this block does
// - Low width pin means 16-bit bus
// - 8-bit bus carries low byte
// - Upper lines only on 16-bit separate bus
// - Drive 20-bit address
// - 8-bit multiplexed: address 0-7 then data
// - 16-bit multiplexed: address 1-8 then data
// - Four active-low area selects
// - Split strobes: even low, odd high
// - Upper lane enable low on odd address
// - Read while read strobe low
// - Address latch pulse before data phase
// - Bus grant always high, no hold support
// - Wait while wait request low
// - Boot pin selects start mode
// - Reset while reset held
`timescale 1ns/1ps
`include "ebi_defines.vh"
module ebi_top (
	// Clock and reset
	input  wire        CORE_CLK,
	input  wire        RST,
	// Straps
	input  wire        BUS_WIDTH_SEL,
	input  wire        BOOT_MODE_SELECT_PIN,
	// Configuration
	input  wire        MUX_MODE,
	input  wire        SINGLE_STROBE_MODE,
	// Core request
	input  wire        REQ_VALID,
	input  wire        REQ_WRITE,
	input  wire [19:0] REQ_ADDR,
	input  wire [1:0]  REQ_AREA,
	input  wire [15:0] REQ_WDATA,
	output reg         REQ_READY,
	output reg         RESP_VALID,
	output reg  [15:0] RESP_RDATA,
	output reg         MICRO_MODE,
	// External bus
	output reg  [19:0] ADDR_OUT,
	input  wire [15:0] DATA_IN,
	output reg  [15:0] DATA_OUT,
	output reg  [15:0] DATA_OE,
	output reg  [3:0]  AREA_SELECT_N,
	output reg         READ_STROBE_N,
	output reg         STORE_STROBE_EVEN,
	output reg         STORE_STROBE_ODD,
	output reg         ADDR_LATCH,
	input  wire        WAIT_REQ_N,
	input  wire        BUS_REQ_N,
	output reg         BUS_GRANT_OUT
);
	localparam [4:0] S_IDLE = 5'h01;
	localparam [4:0] S_ALE  = 5'h02;
	localparam [4:0] S_STRB = 5'h04;
	localparam [4:0] S_WAIT = 5'h08;
	localparam [4:0] S_END  = 5'h10;

	reg  [4:0]  state_q;
	reg  [4:0]  state_d;
	reg         wr_q;
	reg  [19:0] addr_q;
	reg  [15:0] wdata_q;
	reg  [1:0]  area_q;
	reg         bus8_q;
	reg         mux_q;
	reg         single_q;
	reg         strap_done_q;
	wire [15:0] lane_out;
	wire [15:0] lane_oe;
	wire        addr_phase;

	////////////////////////////////////////////////////////////
	assign addr_phase = (state_q == S_ALE);

	ebi_lane u_lane (
		.addr        (addr_q),
		.wdata       (wdata_q),
		.bus8        (bus8_q),
		.mux         (mux_q),
		.addr_phase  (addr_phase),
		.pin_out     (lane_out),
		.pin_oe_mask (lane_oe)
	);

	always @* begin
		state_d = state_q;
		case (state_q)
			S_IDLE: begin
				// Straps must be in before the first access
				if (REQ_VALID && strap_done_q)
					state_d = S_ALE;
			end
			S_ALE: state_d = S_STRB;
			S_STRB: state_d = S_WAIT;
			S_WAIT: begin
				if (WAIT_REQ_N)
					state_d = S_END;
			end
			S_END: state_d = S_IDLE;
			default: state_d = S_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////
	// Straps caught on first clock after reset release
	always @(posedge CORE_CLK) begin
		if (RST) begin
			strap_done_q <= 1'b0;
			MICRO_MODE   <= 1'b0;
			bus8_q       <= 1'b0;
		end else if (!strap_done_q) begin
			strap_done_q <= 1'b1;
			MICRO_MODE   <= BOOT_MODE_SELECT_PIN;
			bus8_q       <= BUS_WIDTH_SEL;
		end
	end

	////////////////////////////////////////////////////////////
	// Access sequencer; one access at a time, no queue
	always @(posedge CORE_CLK) begin
		if (RST) begin
			state_q           <= S_IDLE;
			wr_q              <= 1'b0;
			addr_q            <= 20'h00000;
			wdata_q           <= 16'h0000;
			area_q            <= 2'h0;
			mux_q             <= 1'b0;
			single_q          <= 1'b0;
			REQ_READY         <= 1'b0;
			RESP_VALID        <= 1'b0;
			RESP_RDATA        <= 16'h0000;
			ADDR_OUT          <= 20'h00000;
			DATA_OUT          <= 16'h0000;
			DATA_OE           <= 16'h0000;
			AREA_SELECT_N     <= `EBI_CS_IDLE;
			READ_STROBE_N     <= 1'b1;
			STORE_STROBE_EVEN <= 1'b1;
			STORE_STROBE_ODD  <= 1'b1;
			ADDR_LATCH        <= 1'b0;
			BUS_GRANT_OUT     <= 1'b1;
		end else begin
			state_q       <= state_d;
			REQ_READY     <= 1'b0;
			RESP_VALID    <= 1'b0;
			ADDR_LATCH    <= 1'b0;
			// No hold support, so grant never drops
			BUS_GRANT_OUT <= 1'b1;
			case (state_q)
				S_IDLE: begin
					AREA_SELECT_N     <= `EBI_CS_IDLE;
					READ_STROBE_N     <= 1'b1;
					STORE_STROBE_EVEN <= 1'b1;
					STORE_STROBE_ODD  <= 1'b1;
					DATA_OE           <= 16'h0000;
					if (REQ_VALID && strap_done_q) begin
						REQ_READY <= 1'b1;
						wr_q      <= REQ_WRITE;
						addr_q    <= REQ_ADDR;
						wdata_q   <= REQ_WDATA;
						area_q    <= REQ_AREA;
						mux_q     <= MUX_MODE;
						single_q  <= SINGLE_STROBE_MODE | bus8_q;
						ADDR_OUT  <= REQ_ADDR;
						AREA_SELECT_N <= ~(4'h1 << REQ_AREA);
					end
				end
				S_ALE: begin
					DATA_OUT <= lane_out;
					DATA_OE  <= mux_q ? lane_oe : 16'h0000;
					// Pulse while the mux lines carry the address
					ADDR_LATCH <= 1'b1;
				end
				S_STRB: begin
					DATA_OUT <= lane_out;
					DATA_OE  <= wr_q ? lane_oe : 16'h0000;
					if (!wr_q) begin
						READ_STROBE_N <= 1'b0;
					end
					if (single_q) begin
						// Upper lane enable marks odd reads as well as writes
						STORE_STROBE_EVEN <= ~wr_q;
						STORE_STROBE_ODD  <= ~addr_q[0];
					end else if (wr_q) begin
						STORE_STROBE_EVEN <= addr_q[0];
						STORE_STROBE_ODD  <= ~addr_q[0];
					end
				end
				S_WAIT: begin
					if (WAIT_REQ_N) begin
						if (!wr_q) begin
							RESP_VALID <= 1'b1;
							// Multiplexed and 8-bit buses return on lines 7:0 only
							if (bus8_q || mux_q)
								RESP_RDATA <= {8'h00, DATA_IN[7:0]};
							else if (addr_q[0])
								RESP_RDATA <= {8'h00, DATA_IN[15:8]};
							else
								RESP_RDATA <= DATA_IN;
						end
						READ_STROBE_N     <= 1'b1;
						STORE_STROBE_EVEN <= 1'b1;
						STORE_STROBE_ODD  <= 1'b1;
					end
				end
				S_END: begin
					// Select outlasts the strobe by a cycle for hold time
					AREA_SELECT_N <= `EBI_CS_IDLE;
					DATA_OE       <= 16'h0000;
				end
				default: begin
					AREA_SELECT_N <= `EBI_CS_IDLE;
				end
			endcase
		end
	end
endmodule

// file: common/ebi_defines.vh
// Constants of the external bus interface
`ifndef EBI_DEFINES_VH
`define EBI_DEFINES_VH
`define EBI_ADDR_W      20
`define EBI_DATA_W      16
`define EBI_AREA_W      2
`define EBI_CS_IDLE     4'hf
`define EBI_WAIT_CYC    2'h1
`define EBI_MUX_ADR8_LO 0
`define EBI_MUX_ADR16_LO 1
`endif

// file: rtl/ebi_lane.v
// Data lane steering for the external bus
`timescale 1ns/1ps
module ebi_lane (
	// Access
	input  wire [19:0] addr,
	input  wire [15:0] wdata,
	input  wire        bus8,
	input  wire        mux,
	input  wire        addr_phase,
	// Pins
	output reg  [15:0] pin_out,
	output reg  [15:0] pin_oe_mask
);
	always @* begin
		pin_out     = 16'h0000;
		pin_oe_mask = 16'h0000;
		if (mux) begin
			pin_oe_mask = 16'h00ff;
			if (addr_phase) begin
				if (bus8)
					pin_out[7:0] = addr[7:0];
				else
					pin_out[7:0] = addr[8:1];
			end else if (bus8 || !addr[0]) begin
				pin_out[7:0] = wdata[7:0];
			end else begin
				pin_out[7:0] = wdata[15:8];
			end
		end else if (bus8) begin
			pin_out     = {8'h00, wdata[7:0]};
			pin_oe_mask = 16'h00ff;
		end else begin
			pin_out     = wdata;
			pin_oe_mask = 16'hffff;
		end
	end
endmodule

// file: tb/ebi_top_properties.sv
// Assertions on the external bus pins
`timescale 1ns/1ps
module ebi_props (
	input wire       CORE_CLK, RST, REQ_READY, REQ_WRITE, RESP_VALID, ADDR_LATCH, MICRO_MODE,
	input wire       READ_STROBE_N, STORE_STROBE_EVEN, WAIT_REQ_N, BUS_GRANT_OUT,
	input wire       BOOT_MODE_SELECT_PIN,
	input wire [1:0] REQ_AREA,
	input wire [3:0] AREA_SELECT_N
);
default clocking @(posedge CORE_CLK); endclocking
default disable iff (RST);
property p_sel; REQ_READY |-> AREA_SELECT_N == ~(4'h1 << $past(REQ_AREA)); endproperty
a_sel: assert property (p_sel) else $error("select");
property p_ale; REQ_READY |=> ADDR_LATCH ##1 !ADDR_LATCH; endproperty
a_ale: assert property (p_ale) else $error("latch");
property p_rd; REQ_READY && !$past(REQ_WRITE) |-> ##2 !READ_STROBE_N; endproperty
a_rd: assert property (p_rd) else $error("read strobe");
property p_resp; REQ_READY && !$past(REQ_WRITE) ##2 WAIT_REQ_N |=> RESP_VALID; endproperty
a_resp: assert property (p_resp) else $error("answer");
property p_wait; !READ_STROBE_N && !WAIT_REQ_N |=> !RESP_VALID; endproperty
a_wait: assert property (p_wait) else $error("wait");
property p_idle; AREA_SELECT_N == 4'hf |-> READ_STROBE_N && STORE_STROBE_EVEN; endproperty
a_idle: assert property (p_idle) else $error("idle");
property p_hold; BUS_GRANT_OUT; endproperty
a_hold: assert property (p_hold) else $error("grant");
property p_mode; !$past(RST) |-> MICRO_MODE == BOOT_MODE_SELECT_PIN; endproperty
a_mode: assert property (p_mode) else $error("mode");
c_rd: cover property (RESP_VALID);
c_wt: cover property (!READ_STROBE_N && !WAIT_REQ_N);
c_wr: cover property (!STORE_STROBE_EVEN);
endmodule
bind ebi_top ebi_props u_props (.CORE_CLK, .RST, .REQ_READY, .REQ_WRITE, .RESP_VALID,
	.ADDR_LATCH, .MICRO_MODE, .READ_STROBE_N, .STORE_STROBE_EVEN, .WAIT_REQ_N,
	.BUS_GRANT_OUT, .BOOT_MODE_SELECT_PIN, .REQ_AREA, .AREA_SELECT_N);

// file: tb/ebi_partner.sv
// Memory device on the external bus
`timescale 1ns/1ps
module ebi_mem (
	input wire        CORE_CLK, ADDR_LATCH, READ_STROBE_N, STORE_STROBE_EVEN, STORE_STROBE_ODD,
	input wire [19:0] ADDR_OUT,
	input wire [15:0] DATA_OE, DATA_OUT,
	input wire [3:0]  slow,
	output wire        WAIT_REQ_N,
	output wire [15:0] DATA_IN,
	output reg  [1:0]  ws = 2'h0,
	output reg  [15:0] woe = 16'h0
);
reg [19:0] la = 20'h0;
reg [15:0] tg = 16'h0;
reg [3:0]  cnt = 4'h0;
reg [15:0] wd = 16'h0;
reg [7:0]  ma = 8'h0;
assign WAIT_REQ_N = cnt == 4'h0;
// Toggles when released, so stale data never matches
assign DATA_IN = READ_STROBE_N ? tg : {~la[7:0], la[7:0]};
always @(posedge CORE_CLK) begin
	tg <= ~tg;
	if (ADDR_LATCH) begin
		la <= ADDR_OUT;
		ma <= DATA_OUT[7:0];
		cnt <= slow;
	end else if (cnt != 4'h0)
		cnt <= cnt - 4'h1;
	if (!STORE_STROBE_EVEN || !STORE_STROBE_ODD) begin
		ws <= ~{STORE_STROBE_ODD, STORE_STROBE_EVEN};
		woe <= DATA_OE;
		wd <= DATA_OUT;
	end
end
endmodule

// file: tb/test_ebi_top.sv
// Bench for the external bus interface
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin mismatches++; \
	$display("FAIL %s exp %h got %h", n, e, a); end end
module test_ebi_top;
reg         CORE_CLK = 1'h0, RST = 1'h1, BUS_WIDTH_SEL = 1'h0, BOOT_MODE_SELECT_PIN = 1'h0;
reg         MUX_MODE = 1'h0, SINGLE_STROBE_MODE = 1'h0, REQ_VALID = 1'h0, REQ_WRITE = 1'h0;
reg  [19:0] REQ_ADDR = 20'h0;
reg  [1:0]  REQ_AREA = 2'h0;
reg  [15:0] rd = 16'h0;
reg  [3:0]  slow = 4'h0;
wire        REQ_READY, RESP_VALID, MICRO_MODE, READ_STROBE_N, STORE_STROBE_EVEN;
wire        STORE_STROBE_ODD, ADDR_LATCH, WAIT_REQ_N, BUS_GRANT_OUT;
wire [15:0] RESP_RDATA, DATA_IN, DATA_OE, woe, DATA_OUT;
wire [19:0] ADDR_OUT;
wire [3:0]  AREA_SELECT_N;
wire [1:0]  ws;
integer     mismatches = 0, n_compared = 0, i, k;
always #20 CORE_CLK = ~CORE_CLK;
ebi_top DUT (.CORE_CLK, .RST, .BUS_WIDTH_SEL, .BOOT_MODE_SELECT_PIN, .MUX_MODE,
	.SINGLE_STROBE_MODE, .REQ_VALID, .REQ_WRITE, .REQ_ADDR, .REQ_AREA, .REQ_WDATA(~REQ_ADDR[15:0]),
	.REQ_READY, .RESP_VALID, .RESP_RDATA, .MICRO_MODE, .ADDR_OUT, .DATA_IN, .DATA_OUT,
	.DATA_OE, .AREA_SELECT_N, .READ_STROBE_N, .STORE_STROBE_EVEN, .STORE_STROBE_ODD,
	.ADDR_LATCH, .WAIT_REQ_N, .BUS_REQ_N(1'h1), .BUS_GRANT_OUT);
ebi_mem u_mem (.CORE_CLK, .ADDR_LATCH, .READ_STROBE_N, .STORE_STROBE_EVEN, .STORE_STROBE_ODD,
	.ADDR_OUT, .DATA_OE, .DATA_OUT, .slow, .WAIT_REQ_N, .DATA_IN, .ws, .woe);
task final_report;
	if (mismatches == 0 && n_compared > 0)
		$display("Finished cleanly");
	else
		$display("Finished with errors");
	$finish;
endtask
// Straps only change under reset, as a board would
task restart(input w, input b);
	RST = 1'h1;
	BUS_WIDTH_SEL = w;
	BOOT_MODE_SELECT_PIN = b;
	repeat (10) @(negedge CORE_CLK);
	RST = 1'h0;
	repeat (2) @(negedge CORE_CLK);
endtask
task acc(input w, input [19:0] a, input [1:0] r);
	rd = 16'h0;
	REQ_WRITE = w;
	REQ_ADDR = a;
	REQ_AREA = r;
	REQ_VALID = 1'h1;
	for (k = 0; k < 9 && REQ_READY !== 1'h1; k++) @(negedge CORE_CLK);
	if (k >= 9) mismatches++;
	REQ_VALID = 1'h0;
	for (k = k; k < 40 && AREA_SELECT_N !== 4'hf; k++) begin
		if (RESP_VALID === 1'h1) rd = RESP_RDATA;
		@(negedge CORE_CLK);
	end
	if (k >= 40) mismatches++;
endtask
initial begin
	restart(1'h0, 1'h1);
	`CHK("mode", 1'h1, MICRO_MODE)
	`CHK("grant", 1'h1, BUS_GRANT_OUT)
	for (i = 0; i < 4; i++) begin
		acc(1'h0, 20'h8a130 + i, i[1:0]);
		`CHK("addr", 20'h8a130 + i, u_mem.la)
		`CHK("rdata", ~(8'h30 + i[7:0]), i[0] ? rd[7:0] : rd[15:8])
		`CHK("cycles", 5, k)
	end
	for (i = 0; i < 4; i++) begin
		SINGLE_STROBE_MODE = i[1];
		acc(1'h1, 20'h00500 + i, 2'h2);
		`CHK("strobes", {i[0], ~i[0] | i[1]}, ws)
		`CHK("wdata", ~(16'h0500 + i[15:0]), u_mem.wd)
		`CHK("write lanes", 16'hffff, woe)
	end
	slow = 4'h3;
	acc(1'h0, 20'h00277, 2'h1);
	`CHK("stretched", 8'h88, rd[7:0])
	`CHK("stretch cycles", 8, k)
	slow = 4'h0;
	MUX_MODE = 1'h1;
	acc(1'h1, 20'h00305, 2'h3);
	`CHK("mux lanes", 8'h00, woe[15:8])
	`CHK("mux addr", 8'h82, u_mem.ma)
	`CHK("mux data", 8'hfc, u_mem.wd[7:0])
	acc(1'h0, 20'h00306, 2'h3);
	`CHK("mux read", 8'h06, rd[7:0])
	`CHK("mux read addr", 8'h83, u_mem.ma)
	MUX_MODE = 1'h0;
	restart(1'h1, 1'h0);
	`CHK("mode", 1'h0, MICRO_MODE)
	acc(1'h0, 20'h00411, 2'h0);
	`CHK("byte", 8'h11, rd[7:0])
	MUX_MODE = 1'h1;
	acc(1'h0, 20'h00412, 2'h0);
	`CHK("mux byte", 8'h12, rd[7:0])
	`CHK("mux byte addr", 8'h12, u_mem.ma)
	final_report;
end
initial begin
	#100000;
	mismatches++;
	final_report;
end
endmodule
